// file: design/fofp_consts.svh
// Purpose: Constants for the flag and offset programming block
// Assumes: 131,072 x 18 organisation, single clock at 20 MHz
// Notes: Offsets are 17 bits, split 9 + 8 over two registers
`ifndef FOFP_CONSTS_SVH
`define FOFP_CONSTS_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define FOFP_DATA_W 18
`define FOFP_ADDR_W 17
`define FOFP_CNT_W 18
`define FOFP_OFS_W 17
`define FOFP_OFS_LSB_W 9
`define FOFP_OFS_MSB_W 8
`define FOFP_SER_BITS 34
`define FOFP_SER_IDX_W 6

// ----------------------------------------
// Fill levels and last serial bit index
// ----------------------------------------
`define FOFP_DEPTH 18'h20000
`define FOFP_DEPTH_FALLTHROUGH_MODE 18'h20001
`define FOFP_HALF_LVL 18'h10001
`define FOFP_SER_LAST 6'h21

// ----------------------------------------
// Offset defaults
// ----------------------------------------
`define FOFP_OFS_DEF_SER 17'h003ff
`define FOFP_OFS_DEF_PAR 17'h0007f

`endif

// file: design/fofp_pkg.sv
// Purpose: Types for the flag and offset programming block
// Assumes: Nothing beyond the constants header
// Notes: Offset pointer order is the load and readback order
package fofp_pkg;
    typedef enum logic [1:0] {
        OFS_EMPTY_LSB,
        OFS_EMPTY_MSB,
        OFS_FULL_LSB,
        OFS_FULL_MSB
    } fofp_ofs_sel_t;
endpackage

// file: design/fofp_mem.sv
// Purpose: Storage array of the FIFO, one write and one read port
// Assumes: Both ports on one clock
// Notes: Read data come from a register, one cycle after the request
`timescale 1ns/10ps
`default_nettype none
`include "fofp_consts.svh"

module fofp_mem
    import fofp_pkg::*;
(
    input wire logic clock_in,
    input wire logic wr_en_in,
    input wire logic [`FOFP_ADDR_W-1:0] wr_addr_in,
    input wire logic [`FOFP_DATA_W-1:0] wr_data_in,
    input wire logic rd_en_in,
    input wire logic [`FOFP_ADDR_W-1:0] rd_addr_in,
    output logic [`FOFP_DATA_W-1:0] rd_data_out
);
    logic [`FOFP_DATA_W-1:0] mem_q [0:(1<<`FOFP_ADDR_W)-1];

    // No reset on the array: contents are don't-care until written
    always_ff @(posedge clock_in) begin
        if (wr_en_in) begin
            mem_q[wr_addr_in] <= wr_data_in;
        end
        if (rd_en_in) begin
            rd_data_out <= mem_q[rd_addr_in];
        end
    end
endmodule // fofp_mem
`default_nettype wire

// file: design/fofp_top.sv
// Purpose: FIFO status flags and programmable flag offsets
// Assumes: Write and read sides share clock_in; inputs synchronous
// Notes: Control pins are active low as on the device pins
`timescale 1ns/10ps
`default_nettype none
`include "fofp_consts.svh"

// Summary of operation
// - Standard mode flags from memory fill: empty, n, 65,537, depth-m, full.
// - Fall-through counts output side; ready flags, n+1, above 65,537, 131,073.
// - Master reset sets empty offset to 127 parallel or 1,023 serial.
// - Master reset sets full offset to 127 parallel or 1,023 serial.
// - Load low, write low, read high, serial high, parallel method only: write next offset register.
// - Load low, write high, read low, serial high: present next offset register.
// - Loading method fixed at master reset; same sequence in both modes.
// - Load and serial low: shift one bit per edge, 34 bits, empty LSB first.
// - Load low with serial enable high: no serial shift.
// - Serial load is whole set only; flags invalid until all bits in.
// - Serial shifting pauses and continues with the next bit.
// - Almost-full valid two edges after completion, almost-empty likewise.
// - Offsets read back only in parallel, in any method and mode.
// - Parallel writes cycle empty LSB, empty MSB, full LSB, full MSB.
// - Parallel reads cycle empty LSB, empty MSB, full LSB, full MSB.
// - Independent offset pointers; master reset clears, partial reset keeps.
// - Parallel writing pauses and resumes at the next register.
// - Each partial flag invalid until its own offset words are written.
// - Offset readback pauses and resumes where it stopped.
// - Offset readback replaces the word held on the output port.
// - Load pin during master reset: high serial, low parallel.
// - Mode pin during master reset: high fall-through, low standard.
// - Read ignored when empty; full or not-ready blocks writes.
// - Fall-through: first word reaches output without read enable.
module fofp_top
    import fofp_pkg::*;
(
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic partial_resetn_in,
    input wire logic fallthrough_mode_in,
    input wire logic offset_load_sel_n_in,
    input wire logic write_en_n_in,
    input wire logic read_en_n_in,
    input wire logic serial_enable_n_in,
    input wire logic serial_in,
    input wire logic [`FOFP_DATA_W-1:0] data_in,
    input wire logic out_ready_in,
    output logic [`FOFP_DATA_W-1:0] read_port_out,
    output logic out_valid_out,
    output logic full_flag_n_out,
    output logic input_ready_n_out,
    output logic empty_flag_n_out,
    output logic output_ready_n_out,
    output logic half_full_flag_n_out,
    output logic almost_full_flag_n_out,
    output logic almost_empty_flag_n_out,
    output logic almost_full_valid_out,
    output logic almost_empty_valid_out,
    output logic serial_mode_out,
    output logic fallthrough_out
);
    // ----------------------------------------
    // Operation decode
    // ----------------------------------------
    logic serial_mode_q, serial_mode_d;
    logic fallthrough_mode_q, fallthrough_mode_d;
    logic ld_low;
    logic ofs_wr, ofs_rd, ser_shift, mem_wr, fetch;

    assign ld_low = !offset_load_sel_n_in;
    assign ofs_wr = ld_low && !write_en_n_in && read_en_n_in && serial_enable_n_in && !serial_mode_q;
    assign ofs_rd = ld_low && write_en_n_in && !read_en_n_in && serial_enable_n_in;
    assign ser_shift = ld_low && !serial_enable_n_in && write_en_n_in && read_en_n_in && serial_mode_q;

    // ----------------------------------------
    // Data path state
    // ----------------------------------------
    logic [`FOFP_CNT_W-1:0] mem_cnt_q, mem_cnt_d, total;
    logic [`FOFP_ADDR_W-1:0] wptr_q, wptr_d, rptr_q, rptr_d;
    logic inflight_q, inflight_d;
    logic [1:0] buf_cnt_q, buf_cnt_d;
    logic [`FOFP_DATA_W-1:0] buf0_q, buf0_d, buf1_q, buf1_d;
    logic [`FOFP_DATA_W-1:0] mem_rdata, ofs_word;
    logic room, pop, can_write;
    logic [2:0] occ;

    assign occ = {1'b0, buf_cnt_q} + {2'b00, inflight_q};
    assign room = occ < 3'h2;
    assign total = fallthrough_mode_q ? mem_cnt_q + {16'h0000, buf_cnt_q} + {17'h00000, inflight_q} : mem_cnt_q;
    assign can_write = fallthrough_mode_q ? (total < `FOFP_DEPTH_FALLTHROUGH_MODE) && (mem_cnt_q < `FOFP_DEPTH)
                              : (mem_cnt_q < `FOFP_DEPTH);
    assign mem_wr = offset_load_sel_n_in && !write_en_n_in && can_write;
    // Fall-through pulls the next word without read enable
    assign fetch = (mem_cnt_q != 18'h00000) && room && !ofs_rd
                   && (fallthrough_mode_q || (offset_load_sel_n_in && !read_en_n_in));
    assign pop = (buf_cnt_q != 2'h0) && out_ready_in && (!fallthrough_mode_q || (offset_load_sel_n_in && !read_en_n_in));

    fofp_mem u_mem (
        .clock_in(clock_in),
        .wr_en_in(mem_wr),
        .wr_addr_in(wptr_q),
        .wr_data_in(data_in),
        .rd_en_in(fetch),
        .rd_addr_in(rptr_q),
        .rd_data_out(mem_rdata)
    );

    // ----------------------------------------
    // Offset registers and pointers
    // ----------------------------------------
    logic [`FOFP_OFS_W-1:0] e_ofs_q, e_ofs_d, f_ofs_q, f_ofs_d;
    fofp_ofs_sel_t owp_q, owp_d, orp_q, orp_d;
    logic [`FOFP_SER_IDX_W-1:0] ser_idx_q, ser_idx_d;
    logic e_ok_q, e_ok_d, f_ok_q, f_ok_d;

    always_comb begin
        unique case (orp_q)
            OFS_EMPTY_LSB: ofs_word = {9'h000, e_ofs_q[8:0]};
            OFS_EMPTY_MSB: ofs_word = {10'h000, e_ofs_q[16:9]};
            OFS_FULL_LSB: ofs_word = {9'h000, f_ofs_q[8:0]};
            OFS_FULL_MSB: ofs_word = {10'h000, f_ofs_q[16:9]};
        endcase
    end

    always_comb begin
        serial_mode_d = serial_mode_q;
        fallthrough_mode_d = fallthrough_mode_q;
        e_ofs_d = e_ofs_q;
        f_ofs_d = f_ofs_q;
        owp_d = owp_q;
        orp_d = orp_q;
        ser_idx_d = ser_idx_q;
        e_ok_d = e_ok_q;
        f_ok_d = f_ok_q;
        if (!resetn_in) begin
            // Straps caught at the clock edge while reset is held
            serial_mode_d = offset_load_sel_n_in;
            fallthrough_mode_d = fallthrough_mode_in;
            e_ofs_d = offset_load_sel_n_in ? `FOFP_OFS_DEF_SER : `FOFP_OFS_DEF_PAR;
            f_ofs_d = offset_load_sel_n_in ? `FOFP_OFS_DEF_SER : `FOFP_OFS_DEF_PAR;
            owp_d = OFS_EMPTY_LSB;
            orp_d = OFS_EMPTY_LSB;
            ser_idx_d = 6'h00;
            e_ok_d = 1'b1;
            f_ok_d = 1'b1;
        end else begin
            if (ofs_wr) begin
                unique case (owp_q)
                    OFS_EMPTY_LSB: begin
                        e_ofs_d[8:0] = data_in[8:0];
                        e_ok_d = 1'b0;
                        owp_d = OFS_EMPTY_MSB;
                    end
                    OFS_EMPTY_MSB: begin
                        e_ofs_d[16:9] = data_in[7:0];
                        e_ok_d = 1'b1;
                        owp_d = OFS_FULL_LSB;
                    end
                    OFS_FULL_LSB: begin
                        f_ofs_d[8:0] = data_in[8:0];
                        f_ok_d = 1'b0;
                        owp_d = OFS_FULL_MSB;
                    end
                    OFS_FULL_MSB: begin
                        f_ofs_d[16:9] = data_in[7:0];
                        f_ok_d = 1'b1;
                        owp_d = OFS_EMPTY_LSB;
                    end
                endcase
            end
            if (ofs_rd) begin
                unique case (orp_q)
                    OFS_EMPTY_LSB: orp_d = OFS_EMPTY_MSB;
                    OFS_EMPTY_MSB: orp_d = OFS_FULL_LSB;
                    OFS_FULL_LSB: orp_d = OFS_FULL_MSB;
                    OFS_FULL_MSB: orp_d = OFS_EMPTY_LSB;
                endcase
            end
            if (ser_shift) begin
                // Bit index walks both offsets, empty first
                if (ser_idx_q < 6'h11) begin
                    e_ofs_d[ser_idx_q[4:0]] = serial_in;
                end else begin
                    f_ofs_d[5'(ser_idx_q - 6'h11)] = serial_in;
                end
                if (ser_idx_q == 6'h00) begin
                    e_ok_d = 1'b0;
                    f_ok_d = 1'b0;
                end
                if (ser_idx_q == `FOFP_SER_LAST) begin
                    ser_idx_d = 6'h00;
                    e_ok_d = 1'b1;
                    f_ok_d = 1'b1;
                end else begin
                    ser_idx_d = ser_idx_q + 6'h01;
                end
            end
        end
    end

    always_ff @(posedge clock_in) begin
        serial_mode_q <= serial_mode_d;
        fallthrough_mode_q <= fallthrough_mode_d;
        e_ofs_q <= e_ofs_d;
        f_ofs_q <= f_ofs_d;
        owp_q <= owp_d;
        orp_q <= orp_d;
        ser_idx_q <= ser_idx_d;
        e_ok_q <= e_ok_d;
        f_ok_q <= f_ok_d;
    end

    // ----------------------------------------
    // Memory pointers and two-entry output buffer
    // ----------------------------------------
    always_comb begin
        mem_cnt_d = mem_cnt_q + {17'h00000, mem_wr} - {17'h00000, fetch};
        wptr_d = wptr_q + {16'h0000, mem_wr};
        rptr_d = rptr_q + {16'h0000, fetch};
        inflight_d = fetch;
        buf_cnt_d = buf_cnt_q;
        buf0_d = buf0_q;
        buf1_d = buf1_q;
        if (pop) begin
            buf0_d = buf1_q;
            buf_cnt_d = buf_cnt_q - 2'h1;
        end
        if (ofs_rd) begin
            // Held words are dropped, the offset takes the port
            buf0_d = ofs_word;
            buf_cnt_d = 2'h1;
        end
        if (inflight_q) begin
            if (buf_cnt_d == 2'h0) begin
                buf0_d = mem_rdata;
            end else begin
                buf1_d = mem_rdata;
            end
            buf_cnt_d = buf_cnt_d + 2'h1;
        end
        if (!resetn_in || !partial_resetn_in) begin
            mem_cnt_d = 18'h00000;
            wptr_d = 17'h00000;
            rptr_d = 17'h00000;
            inflight_d = 1'b0;
            buf_cnt_d = 2'h0;
            buf0_d = 18'h00000;
            buf1_d = 18'h00000;
        end
    end

    always_ff @(posedge clock_in) begin
        mem_cnt_q <= mem_cnt_d;
        wptr_q <= wptr_d;
        rptr_q <= rptr_d;
        inflight_q <= inflight_d;
        buf_cnt_q <= buf_cnt_d;
        buf0_q <= buf0_d;
        buf1_q <= buf1_d;
    end

    assign read_port_out = buf0_q;
    assign out_valid_out = buf_cnt_q != 2'h0;

    // ----------------------------------------
    // Flags: raw level compare, then two register stages
    // ----------------------------------------
    logic [`FOFP_CNT_W-1:0] e_n, f_m;
    logic raw_full, raw_ir, raw_empty, raw_or, raw_hf, raw_af, raw_ae;
    logic [6:0] st1_q, st1_d, st2_q, st2_d;
    logic [1:0] ok1_q, ok1_d, ok2_q, ok2_d;

    assign e_n = {1'b0, e_ofs_q};
    assign f_m = {1'b0, f_ofs_q};
    assign raw_full = !(mem_cnt_q == `FOFP_DEPTH);
    assign raw_empty = !(mem_cnt_q == 18'h00000);
    assign raw_ir = total >= `FOFP_DEPTH_FALLTHROUGH_MODE;
    assign raw_or = total == 18'h00000;
    assign raw_hf = fallthrough_mode_q ? !(total > `FOFP_HALF_LVL) : !(total >= `FOFP_HALF_LVL);
    assign raw_af = fallthrough_mode_q ? !(total >= `FOFP_DEPTH_FALLTHROUGH_MODE - f_m) : !(total >= `FOFP_DEPTH - f_m);
    assign raw_ae = fallthrough_mode_q ? !(total <= e_n + 18'h00001) : !(total <= e_n);

    always_comb begin
        st1_d = {raw_full, raw_ir, raw_empty, raw_or, raw_hf, raw_af, raw_ae};
        st2_d = st1_q;
        ok1_d = {f_ok_q, e_ok_q};
        ok2_d = ok1_q;
        if (!resetn_in || !partial_resetn_in) begin
            // Full high, ready low, empty low, out-ready high, hf high, af high, ae low
            st1_d = 7'h4e;
            st2_d = 7'h4e;
        end
        if (!resetn_in) begin
            ok1_d = 2'h3;
            ok2_d = 2'h3;
        end
    end

    always_ff @(posedge clock_in) begin
        st1_q <= st1_d;
        st2_q <= st2_d;
        ok1_q <= ok1_d;
        ok2_q <= ok2_d;
    end

    // Flags of the other mode sit at their idle level
    assign full_flag_n_out = fallthrough_mode_q ? 1'b1 : st2_q[6];
    assign input_ready_n_out = fallthrough_mode_q ? st2_q[5] : 1'b1;
    assign empty_flag_n_out = fallthrough_mode_q ? 1'b1 : st2_q[4];
    assign output_ready_n_out = fallthrough_mode_q ? st2_q[3] : 1'b1;
    assign half_full_flag_n_out = st2_q[2];
    assign almost_full_flag_n_out = st2_q[1];
    assign almost_empty_flag_n_out = st2_q[0];
    assign almost_full_valid_out = ok2_q[1] && f_ok_q;
    assign almost_empty_valid_out = ok2_q[0] && e_ok_q;
    assign serial_mode_out = serial_mode_q;
    assign fallthrough_out = fallthrough_mode_q;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!resetn_in || !partial_resetn_in);

    sequence seq_af_low3;
        !raw_af [*3];
    endsequence

    a_full_blocks_write: assert property (!fallthrough_mode_q && mem_cnt_q == `FOFP_DEPTH |-> !mem_wr)
        else $error("write taken while full");
    a_empty_no_fetch: assert property (mem_cnt_q == 18'h00000 |-> !fetch)
        else $error("read taken while empty");
    a_ofs_wr_wrap: assert property (ofs_wr && owp_q == OFS_FULL_MSB |=> owp_q == OFS_EMPTY_LSB)
        else $error("offset write pointer did not wrap");
    a_ofs_rd_step: assert property (ofs_rd && orp_q == OFS_EMPTY_LSB |=> orp_q == OFS_EMPTY_MSB)
        else $error("offset read pointer did not advance");
    a_ofs_rd_hold: assert property (!ofs_rd |=> $stable(orp_q))
        else $error("offset read pointer moved while paused");
    a_serial_hold: assert property (ld_low && serial_enable_n_in && !ofs_wr |=> $stable(e_ofs_q) && $stable(f_ofs_q))
        else $error("offsets changed without a load");
    a_readback_word: assert property (ofs_rd && !inflight_q |=> out_valid_out && read_port_out == $past(ofs_word))
        else $error("offset readback not on output port");
    a_af_latency: assert property (seq_af_low3 |-> almost_full_flag_n_out == 1'b0)
        else $error("almost-full not low two edges after level");
    a_hf_latency: assert property (raw_hf == 1'b0 ##1 raw_hf == 1'b0 |=> half_full_flag_n_out == 1'b0)
        else $error("half-full late");
    a_ser_complete: assert property (ser_shift && ser_idx_q == `FOFP_SER_LAST |=> ##2 almost_full_valid_out)
        else $error("almost-full not valid after full serial set");
    // Own disable: the default one would mask every partial reset cycle
    a_partial_keeps: assert property (disable iff (!resetn_in) !partial_resetn_in && !ld_low
        |=> $stable(owp_q) && $stable(orp_q) && $stable(e_ofs_q) && $stable(f_ofs_q))
        else $error("partial reset disturbed offsets");
endmodule // fofp_top
`default_nettype wire

// file: tb/fofp_reader.sv
// Purpose: Receiver model at the output buffer of fofp_top
// Assumes: Ready is sampled by the design on the rising edge
// Notes: Stalls one cycle in four, or fully while held
`timescale 1ns/10ps
`default_nettype none

module fofp_reader (
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic hold_in,
    output logic out_ready_out
);
    // ----------------------------------------
    // Stall pattern
    // ----------------------------------------
    logic [1:0] phase_q;
    logic [1:0] phase_d;
    logic ready_q;
    logic ready_d;

    // Registered so ready only moves just after a clock edge
    always_comb begin
        phase_d = phase_q + 2'h1;
        ready_d = !hold_in && (phase_q != 2'h2);
    end

    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            phase_q <= 2'h0;
            ready_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            ready_q <= ready_d;
        end
    end

    assign out_ready_out = ready_q;
endmodule // fofp_reader
`default_nettype wire

// file: tb/fofp_top_tb.sv
// Purpose: Self-checking bench for fofp_top
// Assumes: Falling-edge stimulus; receiver model stalls the buffer
// Notes: Full and half-full levels cost too many cycles to reach
`timescale 1ns/10ps
`default_nettype none
`include "fofp_consts.svh"

module fofp_top_tb
    import fofp_pkg::*;
();
    localparam int watch_cycles = 6000;
    logic clock_in, resetn_in, partial_resetn_in, fallthrough_mode_in, offset_load_sel_n_in;
    logic write_en_n_in, read_en_n_in, serial_enable_n_in, serial_in, out_ready_in, hold;
    logic [`FOFP_DATA_W-1:0] data_in, read_port_out;
    logic out_valid_out, full_flag_n_out, input_ready_n_out, empty_flag_n_out, output_ready_n_out;
    logic half_full_flag_n_out, almost_full_flag_n_out, almost_empty_flag_n_out;
    logic almost_full_valid_out, almost_empty_valid_out, serial_mode_out, fallthrough_out;
    logic [`FOFP_OFS_W-1:0] ofs[2];
    logic [`FOFP_DATA_W-1:0] datq[$], expq[$], gotq[$];
    logic [15:0] lfsr;
    int err_total, cmp_count, cnt, wptr, rptr;
    bit ser, ft;

    fofp_top dut_u (.clock_in(clock_in), .resetn_in(resetn_in), .partial_resetn_in(partial_resetn_in),
        .fallthrough_mode_in(fallthrough_mode_in), .offset_load_sel_n_in(offset_load_sel_n_in),
        .write_en_n_in(write_en_n_in), .read_en_n_in(read_en_n_in), .serial_enable_n_in(serial_enable_n_in),
        .serial_in(serial_in), .data_in(data_in), .out_ready_in(out_ready_in), .read_port_out(read_port_out),
        .out_valid_out(out_valid_out), .full_flag_n_out(full_flag_n_out), .input_ready_n_out(input_ready_n_out),
        .empty_flag_n_out(empty_flag_n_out), .output_ready_n_out(output_ready_n_out),
        .half_full_flag_n_out(half_full_flag_n_out), .almost_full_flag_n_out(almost_full_flag_n_out),
        .almost_empty_flag_n_out(almost_empty_flag_n_out), .almost_full_valid_out(almost_full_valid_out),
        .almost_empty_valid_out(almost_empty_valid_out), .serial_mode_out(serial_mode_out),
        .fallthrough_out(fallthrough_out));

    fofp_reader rdr_u (.clock_in(clock_in), .resetn_in(resetn_in), .hold_in(hold), .out_ready_out(out_ready_in));

    // ----------------------------------------
    // Clock and capture
    // ----------------------------------------
    initial begin
        clock_in = 1'b0;
        forever #25 clock_in = ~clock_in;
    end

    // Fall-through pops also need the read enable
    always @(posedge clock_in) begin
        if (resetn_in && partial_resetn_in && out_valid_out === 1'b1 && out_ready_in
            && (!ft || (offset_load_sel_n_in && !read_en_n_in)))
            gotq.push_back(read_port_out);
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic chk(input logic [`FOFP_DATA_W-1:0] got, input logic [`FOFP_DATA_W-1:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic tick(input int k);
        repeat (k) @(negedge clock_in);
    endtask

    // Order: load select, write enable, read enable, serial enable
    task automatic ctl(input logic [3:0] v);
        {offset_load_sel_n_in, write_en_n_in, read_en_n_in, serial_enable_n_in} = v;
    endtask

    task automatic op(input logic [3:0] v, input logic [`FOFP_DATA_W-1:0] d);
        data_in = d;
        ctl(v);
        tick(1);
        ctl(4'hf);
        tick(1);
    endtask

    task automatic mreset(input bit s, input bit f);
        ser = s;
        ft = f;
        resetn_in = 1'b0;
        fallthrough_mode_in = f;
        ctl({s, 3'h7});
        tick(5);
        resetn_in = 1'b1;
        ctl(4'hf);
        ofs[0] = s ? `FOFP_OFS_DEF_SER : `FOFP_OFS_DEF_PAR;
        ofs[1] = ofs[0];
        {cnt, wptr, rptr} = '0;
        datq.delete();
        tick(1);
        gotq.delete();
        chk({16'h0, serial_mode_out, fallthrough_out}, {16'h0, s, f});
    endtask

    task automatic preset();
        partial_resetn_in = 1'b0;
        tick(2);
        partial_resetn_in = 1'b1;
        cnt = 0;
        datq.delete();
        tick(1);
    endtask

    task automatic wr(input int k);
        repeat (k) begin
            lfsr = lfsr_next(lfsr);
            data_in = {lfsr[1:0], lfsr};
            ctl(4'hb);
            datq.push_back(data_in);
            cnt++;
            tick(1);
        end
        ctl(4'hf);
        tick(1);
    endtask

    task automatic drain(input int k);
        hold = 1'b0;
        ctl(4'hd);
        tick(k);
        ctl(4'hf);
        tick(2);
        while (datq.size() > 0) expq.push_back(datq.pop_front());
        cnt = 0;
    endtask

    task automatic cmpq();
        chk(18'(gotq.size()), 18'(expq.size()));
        while (expq.size() > 0 && gotq.size() > 0) chk(gotq.pop_front(), expq.pop_front());
        gotq.delete();
        expq.delete();
    endtask

    task automatic ofs_wr(input logic [`FOFP_DATA_W-1:0] d);
        if (!ser && wptr[0]) ofs[wptr[1]][16:9] = d[7:0];
        if (!ser && !wptr[0]) ofs[wptr[1]][8:0] = d[8:0];
        if (!ser) wptr = (wptr + 1) % 4;
        op(4'h3, d);
    endtask

    task automatic rdback();
        logic [`FOFP_OFS_W-1:0] v;
        v = ofs[rptr[1]];
        expq.push_back(rptr[0] ? {10'h0, v[16:9]} : {9'h0, v[8:0]});
        rptr = (rptr + 1) % 4;
        op(4'h5, 18'h0);
        drain(6);
    endtask

    task automatic flags();
        int nl, ml;
        logic [8:0] e, g;
        tick(4);
        nl = int'(ofs[0]) + int'(ft);
        ml = int'(ft ? `FOFP_DEPTH_FALLTHROUGH_MODE : `FOFP_DEPTH) - int'(ofs[1]);
        e = {ft || cnt != `FOFP_DEPTH, !ft || cnt >= `FOFP_DEPTH_FALLTHROUGH_MODE, ft || cnt != 0, !ft || cnt == 0,
            !(ft ? cnt > `FOFP_HALF_LVL : cnt >= `FOFP_HALF_LVL), cnt < ml, cnt > nl, 2'h3};
        g = {full_flag_n_out, input_ready_n_out, empty_flag_n_out, output_ready_n_out, half_full_flag_n_out,
            almost_full_flag_n_out, almost_empty_flag_n_out, almost_full_valid_out, almost_empty_valid_out};
        chk({9'h0, g}, {9'h0, e});
    endtask

    task automatic fill(input int k);
        repeat (k) begin
            wr(1);
            flags();
        end
    endtask

    // Pause mid-set with a no-op and a memory write between bits
    task automatic shift(input logic [33:0] v);
        for (int i = 0; i < 34; i++) begin
            serial_in = v[i];
            ctl(4'h6);
            tick(1);
            if (i == 16) begin
                serial_in = ~v[17];
                ctl(4'h7);
                tick(1);
                chk({17'h0, almost_full_valid_out}, 18'h0);
                wr(1);
            end
        end
        ctl(4'hf);
        chk({16'h0, almost_full_valid_out, almost_empty_valid_out}, 18'h0);
        tick(2);
        chk({16'h0, almost_full_valid_out, almost_empty_valid_out}, 18'h3);
        ofs[0] = v[16:0];
        ofs[1] = v[33:17];
    endtask

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        {resetn_in, partial_resetn_in, fallthrough_mode_in, serial_in, hold} = 5'h08;
        data_in = 18'h0;
        ctl(4'hf);
        lfsr = 16'h005f;
        mreset(1'b0, 1'b0);
        flags();
        repeat (5) rdback();
        cmpq();
        ofs_wr(18'h3);
        ofs_wr(18'h0);
        wr(1);
        ofs_wr(18'h1fe);
        ofs_wr(18'hff);
        ofs_wr(18'h2);
        ofs_wr(18'h0);
        flags();
        fill(3);
        drain(20);
        cmpq();
        repeat (4) rdback();
        cmpq();
        wr(1);
        tick(4);
        hold = 1'b1;
        op(4'hd, 18'h0);
        tick(3);
        // Held word is overwritten by the readback, so nothing of it is expected
        datq.delete();
        rdback();
        cmpq();
        preset();
        flags();
        repeat (2) rdback();
        cmpq();
        $display("test parallel_standard done");
        mreset(1'b1, 1'b1);
        flags();
        ofs_wr(18'h0);
        repeat (4) rdback();
        cmpq();
        shift({17'h1fffe, 17'h00001});
        flags();
        fill(3);
        drain(20);
        cmpq();
        repeat (4) rdback();
        cmpq();
        $display("test serial_fallthrough done");
        results();
    end

    initial begin
        repeat (watch_cycles) @(posedge clock_in);
        err_total++;
        results();
    end
endmodule // fofp_top_tb
`default_nettype wire
